// >>> csio_pkg.sv
/*
  Package for the processor special I/O control block: instruction field
  positions, opcodes, control codes, APB register map and reset values.
  Assumes 16-bit instruction and data words, bit 0 numbered as the MSB.
*/
`default_nettype none
package csio_pkg;

  // ==========================================================
  // Instruction fields (bit 0 is the MSB, bit 15 the LSB)
  localparam logic [2:0]  IO_CLASS      = 3'b011;
  localparam logic [5:0]  CPU_CODE      = 6'o77;
  localparam int          CLASS_MSB     = 15;
  localparam int          AC_LSB        = 11;
  localparam int          OP_LSB        = 8;
  localparam int          CTL_LSB       = 6;
  localparam int          DEV_LSB       = 0;

  // ==========================================================
  // Transfer opcodes, bits 5-7
  localparam logic [2:0]  OP_NONE       = 3'b000;
  localparam logic [2:0]  OP_DIN_A      = 3'b001;
  localparam logic [2:0]  OP_DOUT_A     = 3'b010;
  localparam logic [2:0]  OP_DIN_B      = 3'b011;
  localparam logic [2:0]  OP_DOUT_B     = 3'b100;
  localparam logic [2:0]  OP_DIN_C      = 3'b101;
  localparam logic [2:0]  OP_DOUT_C     = 3'b110;
  localparam logic [2:0]  OP_SKIP       = 3'b111;

  // ==========================================================
  // Control codes, bits 8-9
  localparam logic [1:0]  CTL_NONE      = 2'b00;
  localparam logic [1:0]  CTL_START     = 2'b01;
  localparam logic [1:0]  CTL_CLEAR     = 2'b10;
  localparam logic [1:0]  CTL_PULSE     = 2'b11;

  // ==========================================================
  // APB register map (byte addresses)
  localparam logic [7:0]  REG_INSTR     = 8'h00;
  localparam logic [7:0]  REG_ACC       = 8'h04;
  localparam logic [7:0]  REG_RESULT    = 8'h08;
  localparam logic [7:0]  REG_STATUS    = 8'h0C;
  localparam logic [7:0]  REG_IRQ_STAT  = 8'h10;
  localparam logic [7:0]  REG_IRQ_MASK  = 8'h14;
  localparam logic [7:0]  REG_CTRL      = 8'h18;

  // Status bit positions
  localparam int          ST_ION        = 0;
  localparam int          ST_PWRFAIL    = 1;
  localparam int          ST_MODE64     = 2;
  localparam int          ST_HALT       = 3;
  localparam int          ST_SKIP       = 4;
  localparam int          ST_ARMED      = 5;

  // Interrupt event bits
  localparam int          EV_DONE       = 0;
  localparam int          EV_HALT       = 1;
  localparam int          EV_PWRFAIL    = 2;
  localparam int          EV_W          = 3;

  // Control register bits
  localparam int          CT_RESTART    = 0;
  localparam int          CT_SVC        = 1;
  localparam int          CT_PF_CLR     = 2;
  localparam int          CT_INSN_DONE  = 3;

  localparam logic [15:0] WORD_ZERO     = 16'h0000;
  localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

  // ==========================================================
  // Bus towards the peripheral controllers
  typedef struct packed {
    logic [5:0]  dev_sel;
    logic        start_pulse_line;
    logic        clear_pulse_line;
    logic        general_pulse_line;
    logic        mask_out_broadcast;
    logic        io_reset_all;
    logic [15:0] data;
  } csio_bus_s;

  // Decode FSM, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_XFER  = 3'b010,
    ST_PULSE = 3'b100
  } csio_state_e;

endpackage
`default_nettype wire

// >>> csio_ctrl.sv
/*
  Processor special I/O control: decodes I/O-class instructions written
  over APB and carries out device-code-77 functions; other codes are
  forwarded on the device bus. Assumes one 200 MHz clock, the core writing
  the instruction register, and peripherals answering the interrupt
  acknowledge through intack_code within the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Overview of operation
// - Device code 77 in an I/O instruction means a processor control op.
// - Data in A reads the switches; data out A does nothing.
// - Start pulse sets interrupt-on; requests wait one more instruction.
// - Clear pulse resets interrupt-on; requests ignored until set again.
// - General pulse picks 32K or 64K addressing from accumulator LSB.
// - Buffer B transfers broadcast to all devices for interrupt control.
// - Ack read returns code of highest-priority requesting device.
// - Mask-out drives accumulator to all devices; ones disable interrupts.
// - I/O reset: clear devices and interrupt-on, force 32K, keep acc.
// - Data in C without clear resets devices but keeps interrupt-on.
// - Data out C halts until the operator restarts.
// - Start with switch read: finish the read, then set interrupt-on.
// - Busy is interrupt-on; done is power-fail latch, interrupting if on.
// - Skip codes 00/01 test interrupt-on set/clear, 10/11 power-fail.
// - I/O class is 011 in the three top instruction bits.
// - Six-bit device field is driven onto the device select lines.
// - Data transfer completes before the control pulse is issued.
// - Interrupt service start clears interrupt-on automatically.
module csio_ctrl
  import csio_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] switches,
  input  wire logic        pwr_fail_pin,
  input  wire logic [5:0]  intack_code,
  input  wire logic        dev_int_req,
  output csio_bus_s        io_bus,
  output logic             irq_to_core,
  output logic             halted,
  output logic             mode_64k,
  output logic             irq
);

  // ==========================================================
  // Register state
  logic [15:0]      instr_r;
  logic [15:0]      acc_r;
  logic [15:0]      result_r;
  logic             ion_r;
  logic             armed_r;
  logic             pf_r;
  logic             skip_r;
  logic [EV_W-1:0]  ev_stat_r;
  logic [EV_W-1:0]  ev_mask_r;
  logic [2:0]       pf_sync_r;
  csio_state_e      state_r;
  logic             busy_done_ack;

  // ==========================================================
  // APB access decode; slave answers in the access phase, no waits
  logic wr_en;
  logic rd_en;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  logic wr_instr;
  logic wr_ctrl;
  assign wr_instr = wr_en && (paddr == REG_INSTR) && state_r == ST_IDLE
                    && !halted;
  assign wr_ctrl  = wr_en && (paddr == REG_CTRL);

  // Instruction fields
  logic       is_io;
  logic       is_cpu;
  logic [1:0] ac_sel;
  logic [2:0] opc;
  logic [1:0] ctl;
  assign is_io  = (pwdata[CLASS_MSB -: 3] == IO_CLASS);
  assign ac_sel = instr_r[AC_LSB +: 2];
  assign opc    = instr_r[OP_LSB +: 3];
  assign ctl    = instr_r[CTL_LSB +: 2];
  assign is_cpu = (instr_r[DEV_LSB +: 6] == CPU_CODE);

  // ==========================================================
  // Decode sequence: transfer phase, then pulse phase
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= ST_IDLE;
    else
      case (state_r)
        ST_IDLE:  state_r <= wr_instr && is_io ? ST_XFER : ST_IDLE;
        ST_XFER:  state_r <= ST_PULSE;
        ST_PULSE: state_r <= ST_IDLE;
        default:  state_r <= ST_IDLE;
      endcase
  end

  // Latch the instruction and the accumulator operand
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      instr_r <= WORD_ZERO;
      acc_r   <= WORD_ZERO;
    end
    else
    begin
      if (wr_instr)
        instr_r <= pwdata[15:0];
      if (wr_en && paddr == REG_ACC)
        acc_r <= pwdata[15:0];
    end
  end

  // Data-in results land in the accumulator result register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      result_r <= WORD_ZERO;
    else if (state_r == ST_XFER && is_cpu)
      case (opc)
        OP_DIN_A: result_r <= switches;
        OP_DIN_B: result_r <= {10'h000, intack_code};
        default:  result_r <= acc_r;      // Accumulator unchanged
      endcase
    else if (state_r == ST_XFER && opc != OP_SKIP)
      result_r <= acc_r;
  end

  // Skip outcome for the core
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      skip_r <= 1'b0;
    else if (state_r == ST_XFER && is_cpu && opc == OP_SKIP)
      case (ctl)
        2'b00:   skip_r <= ion_r;
        2'b01:   skip_r <= ~ion_r;
        2'b10:   skip_r <= pf_r;
        default: skip_r <= ~pf_r;
      endcase
    else if (state_r == ST_XFER)
      skip_r <= 1'b0;
  end

  // ==========================================================
  // Bus to peripherals: data phase first, pulse one cycle later
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      io_bus <= '0;
    else
    begin
      io_bus.start_pulse_line   <= 1'b0;
      io_bus.clear_pulse_line   <= 1'b0;
      io_bus.general_pulse_line <= 1'b0;
      io_bus.mask_out_broadcast <= 1'b0;
      io_bus.io_reset_all       <= 1'b0;
      if (state_r == ST_XFER)
      begin
        io_bus.dev_sel <= instr_r[DEV_LSB +: 6];
        io_bus.data    <= acc_r;
        if (is_cpu && opc == OP_DOUT_B)
          io_bus.mask_out_broadcast <= 1'b1;
        if (is_cpu && opc == OP_DIN_C)
          io_bus.io_reset_all <= 1'b1;
      end
      else if (state_r == ST_PULSE && !is_cpu && opc != OP_SKIP)
      begin
        io_bus.start_pulse_line   <= (ctl == CTL_START);
        io_bus.clear_pulse_line   <= (ctl == CTL_CLEAR);
        io_bus.general_pulse_line <= (ctl == CTL_PULSE);
      end
    end
  end

  // ==========================================================
  // Interrupt-on flag and one-instruction arming delay
  logic svc_start;
  logic insn_done;
  assign svc_start = wr_ctrl && pwdata[CT_SVC];
  assign insn_done = wr_ctrl && pwdata[CT_INSN_DONE];

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ion_r   <= 1'b0;
      armed_r <= 1'b0;
    end
    else if (state_r == ST_PULSE && is_cpu && opc != OP_SKIP
             && ctl == CTL_CLEAR)
    begin
      ion_r   <= 1'b0;
      armed_r <= 1'b0;
    end
    else if (state_r == ST_PULSE && is_cpu && opc != OP_SKIP
             && ctl == CTL_START)
    begin
      ion_r   <= 1'b1;                     // After the read
      armed_r <= 1'b0;
    end
    else if (svc_start)
    begin
      ion_r   <= 1'b0;
      armed_r <= 1'b0;
    end
    else if (insn_done && ion_r)
      armed_r <= 1'b1;                 // One instruction has passed
  end

  // Addressing mode, LSB of accumulator zero
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mode_64k <= 1'b0;
    else if (state_r == ST_PULSE && is_cpu && opc == OP_DIN_C
             && ctl == CTL_CLEAR)
      mode_64k <= 1'b0;
    else if (state_r == ST_PULSE && is_cpu && opc != OP_SKIP
             && ctl == CTL_PULSE)
      mode_64k <= acc_r[0];
  end

  // Halt until the operator restart bit is written
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      halted <= 1'b0;
    else if (state_r == ST_XFER && is_cpu && opc == OP_DOUT_C)
      halted <= 1'b1;
    else if (wr_ctrl && pwdata[CT_RESTART])
      halted <= 1'b0;
  end

  // ==========================================================
  // Power-fail pin: three stages, a fault counts when stages 2 and 3 are both high
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pf_sync_r <= 3'b000;
    else
      pf_sync_r <= {pf_sync_r[1:0], pwr_fail_pin};
  end

  logic pf_event;
  assign pf_event = pf_sync_r[2] & pf_sync_r[1] & ~pf_r;

  // Latch holds until software clears it; a new fault wins over the clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pf_r <= 1'b0;
    else if (pf_sync_r[2] & pf_sync_r[1])
      pf_r <= 1'b1;
    else if (wr_ctrl && pwdata[CT_PF_CLR])
      pf_r <= 1'b0;
  end

  // Interrupt into the core: devices or power fail, only when armed
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq_to_core <= 1'b0;
    else
      irq_to_core <= ion_r & armed_r & (dev_int_req | pf_r);
  end

  // ==========================================================
  // Sticky event status, write one to clear, set wins
  logic [EV_W-1:0] ev_set;
  assign busy_done_ack = (state_r == ST_PULSE);
  assign ev_set = {pf_event,
                   state_r == ST_XFER && is_cpu && opc == OP_DOUT_C,
                   busy_done_ack};

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ev_stat_r <= '0;
    else if (wr_en && paddr == REG_IRQ_STAT)
      ev_stat_r <= (ev_stat_r & ~pwdata[EV_W-1:0]) | ev_set;
    else
      ev_stat_r <= ev_stat_r | ev_set;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ev_mask_r <= '0;
    else if (wr_en && paddr == REG_IRQ_MASK)
      ev_mask_r <= pwdata[EV_W-1:0];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(ev_stat_r & ev_mask_r);
  end

  // ==========================================================
  // APB read data, registered in the setup cycle
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = RD_ZERO;
    case (paddr)
      REG_INSTR:    rd_mux = {16'h0000, instr_r};
      REG_ACC:      rd_mux = {16'h0000, acc_r};
      REG_RESULT:   rd_mux = {16'h0000, result_r};
      REG_STATUS:   rd_mux = {26'h000_0000, armed_r, skip_r, halted,
                              mode_64k, pf_r, ion_r};
      REG_IRQ_STAT: rd_mux = {29'h0000_0000, ev_stat_r};
      REG_IRQ_MASK: rd_mux = {29'h0000_0000, ev_mask_r};
      REG_CTRL:     rd_mux = RD_ZERO;
      default:      rd_mux = RD_ZERO;
    endcase
  end

  logic addr_ok;
  assign addr_ok = (paddr <= REG_CTRL) && (paddr[1:0] == 2'b00);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= RD_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;        // Ready in the first access cycle
      pslverr <= psel & ~penable & ~addr_ok;
      if (psel & ~penable & ~pwrite)
        prdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// >>> csio_monitor.sv
/* Concurrent checks on the csio_ctrl ports.
   Assumes the bind below and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module csio_monitor
  import csio_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire csio_bus_s   io_bus,
  input wire logic        halted
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Sequences
  sequence insn_wr_s;
    psel && penable && pready && pwrite && paddr == REG_INSTR && !halted;
  endsequence
  sequence regular_start_s;
    pwdata[15:13] == IO_CLASS && pwdata[5:0] != CPU_CODE
      && pwdata[7:6] == CTL_START && pwdata[10:8] != OP_SKIP;
  endsequence
  // Restart strobe as a plain term, since a sequence cannot be negated
  logic restart_w;
  assign restart_w = psel && penable && pwrite && paddr == REG_CTRL
                     && pwdata[CT_RESTART];
  // ==========================================================
  // Bus handshake, one access cycle always
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  slverr_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // Halt persists until the operator restart
  halt_held_a: assert property (halted && !restart_w |=> halted)
    else $error("halt dropped without restart");
  // The start pulse is accepted two or three cycles after the instruction write
  start_after_xfer_a: assert property (insn_wr_s ##0 regular_start_s
    |-> ##[2:3] io_bus.start_pulse_line)
    else $error("start pulse missing or early");
  clear_single_a: assert property (io_bus.clear_pulse_line
    |=> !io_bus.clear_pulse_line)
    else $error("clear pulse longer than a cycle");
  mask_cpu_sel_a: assert property (io_bus.mask_out_broadcast
    |-> io_bus.dev_sel == CPU_CODE)
    else $error("mask broadcast with wrong select");
endmodule
bind csio_ctrl csio_monitor csio_monitor_i (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .io_bus(io_bus), .halted(halted)
);
`default_nettype wire

// >>> csio_periph_model.sv
/* Peripheral controllers seen from the device bus.
   Assumes a registered io_bus and a single requester. */
`timescale 1ns/1ps
`default_nettype none
module csio_periph_model
  import csio_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire csio_bus_s   io_bus,
  input  wire logic        req_on,
  input  wire logic [5:0]  req_code,
  output logic      [5:0]  intack_code,
  output logic             dev_int_req,
  output logic      [15:0] mask_r,
  output logic      [5:0]  last_dev,
  output logic      [15:0] last_data,
  output logic      [2:0]  last_pulse
);
  // ==========================================================
  // Interrupt disable flags; reset wins over a mask word
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mask_r <= 16'h0000;
    else if (io_bus.io_reset_all)
      mask_r <= 16'h0000;
    else if (io_bus.mask_out_broadcast)
      mask_r <= io_bus.data;
  end
  // Addressed device latches select, data and pulse kind at any pulse
  logic any_pulse;
  assign any_pulse = io_bus.start_pulse_line | io_bus.clear_pulse_line
                     | io_bus.general_pulse_line;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_dev   <= 6'h00;
      last_pulse <= 3'b000;
    end
    else if (any_pulse)
    begin
      last_dev   <= io_bus.dev_sel;
      last_pulse <= {io_bus.start_pulse_line, io_bus.clear_pulse_line,
                     io_bus.general_pulse_line};
    end
  end
  always_ff @(posedge clock)
  begin
    if (any_pulse)
      last_data <= io_bus.data;
  end
  // Code 00 is the default answer when nobody requests
  assign intack_code = req_on ? req_code : 6'h00;
  assign dev_int_req = req_on && !mask_r[0];
endmodule
`default_nettype wire

// >>> csio_ctrl_tb_top.sv
/* Self-checking bench for csio_ctrl over APB.
   Assumes the monitor bind and the peripheral model. */
`timescale 1ns/1ps
`default_nettype none
module csio_ctrl_tb_top
  import csio_pkg::*;
;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] switches, mask_r, last_data, v;
  logic [5:0] intack_code, req_code, last_dev, dv;
  logic pwr_fail_pin, dev_int_req, irq_to_core, halted, mode_64k, irq;
  logic req_on, rerr;
  logic [2:0] last_pulse;
  csio_bus_s io_bus;
  int n_errors, checks_done;
  csio_ctrl csio_ctrl_i (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switches(switches), .pwr_fail_pin(pwr_fail_pin),
    .intack_code(intack_code), .dev_int_req(dev_int_req),
    .io_bus(io_bus), .irq_to_core(irq_to_core), .halted(halted),
    .mode_64k(mode_64k), .irq(irq));
  csio_periph_model csio_periph_model_i (.clock(clock), .rst_n(rst_n),
    .io_bus(io_bus), .req_on(req_on), .req_code(req_code),
    .intack_code(intack_code), .dev_int_req(dev_int_req),
    .mask_r(mask_r), .last_dev(last_dev), .last_data(last_data),
    .last_pulse(last_pulse));
  // ==========================================================
  // Checking and bus helpers
  function automatic logic skip_exp(logic [1:0] c, logic on, logic pf);
    return (c[1] ? pf : on) ^ c[0];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One setup and access; the request holds until pready, and only the
  // watchdog ends a wait that never gets an answer
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Operand first, then the word; gap covers the decode time
  task automatic exec(input logic [1:0] ac, input logic [2:0] op,
    input logic [1:0] ctl, input logic [5:0] dev, input logic [15:0] a);
    apb(1'b1, REG_ACC, {16'h0000, a});
    apb(1'b1, REG_INSTR, {16'h0000, IO_CLASS, ac, op, ctl, dev});
    repeat (4) @(posedge clock);
  endtask
  task automatic st_chk(input int i, input logic e);
    apb(1'b0, REG_STATUS, RD_ZERO);
    chk(32'(rd[i]), 32'(e));
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // Clock and watchdog; the run needs about 500 cycles
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    n_errors++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {switches, pwr_fail_pin, req_on, req_code, rst_n} = '0;
    n_errors = 0;
    checks_done = 0;
    void'($urandom(75));
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, REG_STATUS, RD_ZERO);
    chk(rd, RD_ZERO);
    apb(1'b0, 8'h1C, RD_ZERO);
    chk({rd[31:1], rerr}, 32'h0000_0001);
    // Switch read, then interrupts on
    switches <= 16'($urandom);
    exec(2'd3, OP_DIN_A, CTL_START, CPU_CODE, 16'h0000);
    apb(1'b0, REG_RESULT, RD_ZERO);
    chk(rd, {16'h0000, switches});
    st_chk(ST_ION, 1'b1);
    // Every skip code against every flag pairing
    for (int pf = 0; pf < 2; pf++)
    begin
      pwr_fail_pin <= pf[0];
      repeat (8) @(posedge clock);
      for (int on = 0; on < 2; on++)
      begin
        exec(2'd0, OP_NONE, on ? CTL_START : CTL_CLEAR, CPU_CODE, 16'h0000);
        st_chk(ST_ION, on[0]);
        st_chk(ST_PWRFAIL, pf[0]);
        for (int c = 0; c < 4; c++)
        begin
          exec(2'd0, OP_SKIP, 2'(c), CPU_CODE, 16'h0000);
          st_chk(ST_SKIP, skip_exp(2'(c), on[0], pf[0]));
        end
      end
    end
    // Addressing mode from the operand LSB, ending in 64K
    for (int i = 0; i < 3; i++)
    begin
      exec(2'd0, OP_NONE, CTL_PULSE, CPU_CODE, {15'($urandom), ~i[0]});
      chk(32'(mode_64k), {31'h0000_0000, ~i[0]});
    end
    // Mask broadcast, random then all ones
    v = 16'($urandom);
    for (int i = 0; i < 2; i++)
    begin
      exec(2'd1, OP_DOUT_B, CTL_NONE, CPU_CODE, v);
      chk(32'(mask_r), 32'(v));
      v = 16'hFFFF;
    end
    // Acknowledge read of the requesting code
    dv = 6'($urandom_range(1, 62));
    req_code <= dv;
    req_on <= 1'b1;
    exec(2'd2, OP_DIN_B, CTL_NONE, CPU_CODE, 16'h0000);
    apb(1'b0, REG_RESULT, RD_ZERO);
    chk(rd, 32'(dv));
    // Device reset that keeps interrupts on, then the full one
    exec(2'd0, OP_NONE, CTL_START, CPU_CODE, 16'h0000);
    v = 16'($urandom);
    exec(2'd0, OP_DIN_C, CTL_NONE, CPU_CODE, v);
    st_chk(ST_ION, 1'b1);
    chk(32'(mask_r), RD_ZERO);
    chk(32'(irq_to_core), RD_ZERO);
    apb(1'b1, REG_CTRL, 32'(1 << CT_INSN_DONE));
    repeat (2) @(posedge clock);
    chk(32'(irq_to_core), 32'h0000_0001);
    apb(1'b1, REG_CTRL, 32'(1 << CT_SVC));
    st_chk(ST_ION, 1'b0);
    exec(2'd0, OP_DIN_C, CTL_CLEAR, CPU_CODE, v);
    chk(32'(mode_64k), RD_ZERO);
    apb(1'b0, REG_RESULT, RD_ZERO);
    chk(rd, 32'(v));
    // Halt, refused word, interrupt raised and cleared
    apb(1'b1, REG_IRQ_MASK, 32'(1 << EV_HALT));
    exec(2'd0, OP_DOUT_C, CTL_NONE, CPU_CODE, 16'h0000);
    chk(32'(halted), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    exec(2'd0, OP_NONE, CTL_START, CPU_CODE, 16'h0000);
    st_chk(ST_ION, 1'b0);
    apb(1'b1, REG_CTRL, 32'(1 << CT_RESTART));
    apb(1'b1, REG_IRQ_STAT, 32'(1 << EV_HALT));
    repeat (2) @(posedge clock);
    chk({30'h0000_0000, halted, irq}, RD_ZERO);
    // Regular device gets select and data before each kind of pulse
    for (int k = 1; k < 4; k++)
    begin
      dv = 6'($urandom_range(1, 62));
      v = 16'($urandom);
      exec(2'd1, OP_DOUT_A, 2'(k), dv, v);
      chk(32'(last_dev), 32'(dv));
      chk(32'(last_data), 32'(v));
      chk(32'(last_pulse), 32'(4 >> (k - 1)));
    end
    conclude();
  end
endmodule
`default_nettype wire
